// *** bench/probe_model.sv ***
// stand-in for the probed signals feeding the trigger comparators
module probe_model
(
	// clock, reset and levels asked for by the bench
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [1:0] ch,
	input wire logic [7:0] dig,
	// comparator levels
	output logic ch1_above,
	output logic ch2_above,
	output logic [7:0] digital_in,
	output logic mains
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] cnt_ff;
	// channel and probe levels pass straight through
	assign ch1_above = ch[0];
	assign ch2_above = ch[1];
	assign digital_in = dig;
	// mains runs free; period cut to 100 cycles to keep runs short
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff <= 6'h0;
			mains <= 1'b0;
		end
		else if (cnt_ff == 6'h31)
		begin
			cnt_ff <= 6'h0;
			mains <= !mains;
		end
		else
			cnt_ff <= cnt_ff + 6'h1;
	end
endmodule

// *** bench/tb.sv ***
// self-checking bench for the trigger decision unit
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic REF_CLK, RESETN, RUN_MODE_TOGGLE, SINGLE_PRESS, SLOPE_PRESS;
	logic AUTOMATIC_SETUP, TYPE_WRITE, COUPLING_WRITE, PROBE_PRESENT;
	logic NEGATIVE_POLARITY, HOLDOFF_EN, CH1_ABOVE, CH2_ABOVE;
	logic MAINS_LINE_SOURCE, TRIGGER, FORCED, NORMAL_LAMP, RUN_LAMP, STOPPED;
	logic ACQ_ACCEPT, PEAK_LIMIT_EN, LOWPASS_COUPLING;
	logic NOISE_REDUCTION_COUPLING, HIGH_FREQ_REJECT_COUPLING;
	logic [2:0] TYPE_SEL, COUPLING_SEL, DIGITAL_SEL, CMP_SEL, TYPE_ACTIVE;
	logic [2:0] COUPLING_ACTIVE;
	logic [1:0] SOURCE_SEL, SLOPE_ACTIVE, lvl;
	logic [7:0] DIGITAL_IN, dig;
	logic [35:0] REF_T1_NS, REF_T2_NS;
	logic [16:0] DEV_STEPS;
	logic [33:0] HOLDOFF_NS;
	int fail_count = 0;
	int n_compared = 0;
	int c1, c2, c;
	// polarity, compare code, width in cycles, trigger expected
	int tbl[11][4] = '{'{0, 0, 8, 1}, '{0, 0, 3, 0}, '{0, 1, 3, 1},
		'{0, 2, 5, 1}, '{0, 2, 8, 0}, '{0, 3, 8, 1}, '{0, 4, 7, 1},
		'{0, 4, 3, 0}, '{0, 5, 3, 1}, '{0, 5, 7, 0}, '{1, 0, 8, 1}};

	scope_trigger_unit #(.AUTO_TIMEOUT(20)) dut_u (.REF_CLK, .RESETN,
		.RUN_MODE_TOGGLE, .SINGLE_PRESS, .SLOPE_PRESS, .AUTOMATIC_SETUP,
		.TYPE_WRITE, .TYPE_SEL, .COUPLING_WRITE, .COUPLING_SEL, .SOURCE_SEL,
		.DIGITAL_SEL, .PROBE_PRESENT, .NEGATIVE_POLARITY, .CMP_SEL,
		.REF_T1_NS, .REF_T2_NS, .DEV_STEPS, .HOLDOFF_EN, .HOLDOFF_NS,
		.CH1_ABOVE, .CH2_ABOVE, .DIGITAL_IN, .MAINS_LINE_SOURCE, .TRIGGER,
		.FORCED, .NORMAL_LAMP, .RUN_LAMP, .STOPPED, .ACQ_ACCEPT,
		.PEAK_LIMIT_EN, .LOWPASS_COUPLING, .NOISE_REDUCTION_COUPLING,
		.HIGH_FREQ_REJECT_COUPLING, .TYPE_ACTIVE, .SLOPE_ACTIVE,
		.COUPLING_ACTIVE);
	probe_model probe_u (.ref_clk(REF_CLK), .resetn(RESETN), .ch(lvl),
		.dig(dig), .ch1_above(CH1_ABOVE), .ch2_above(CH2_ABOVE),
		.digital_in(DIGITAL_IN), .mains(MAINS_LINE_SOURCE));

	// 10 MHz sample clock
	initial
	begin
		REF_CLK = 1'b0;
		forever #50 REF_CLK = ~REF_CLK;
	end

	// inputs move 10 ns after the edge so sampling never races
	task tick(input int n = 1);
		repeat (n) @(posedge REF_CLK);
		#10;
	endtask

	// one-cycle strobe, then a gap so back-to-back calls stay distinct
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
		tick();
	endtask

	task chk(input logic [15:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// triggers seen over n cycles
	task count(input int n, output int k);
		k = 0;
		repeat (n)
		begin
			tick();
			// an unknown trigger must not pass as a quiet cycle
			k += (TRIGGER === 1'b1) ? 1 : (TRIGGER === 1'b0) ? 0 : 8;
		end
	endtask

	// bounded wait; running out ends the run as a mismatch
	task wait_trig(input int n);
		int i;
		i = 0;
		while (TRIGGER !== 1'b1 && i < n)
		begin
			tick();
			i++;
		end
		if (TRIGGER !== 1'b1)
		begin
			fail_count++;
			$display("unexpected timeout at %0t: got %h exp %h", $time, 0, 1);
			conclude();
		end
	endtask

	task conclude();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		{RUN_MODE_TOGGLE, SINGLE_PRESS, SLOPE_PRESS, AUTOMATIC_SETUP} = 4'h0;
		{TYPE_WRITE, COUPLING_WRITE, PROBE_PRESENT, HOLDOFF_EN} = 4'h0;
		{TYPE_SEL, COUPLING_SEL, DIGITAL_SEL, CMP_SEL} = 12'h0;
		{NEGATIVE_POLARITY, SOURCE_SEL, lvl, dig} = 13'h0;
		REF_T1_NS = 36'h1f4;
		REF_T2_NS = 36'h384;
		DEV_STEPS = 17'hd;
		HOLDOFF_NS = 34'h3e8;
		RESETN = 1'b0;
		repeat (20) @(posedge REF_CLK);
		#10 RESETN = 1'b1;
		tick();
		chk({TYPE_ACTIVE, SLOPE_ACTIVE, COUPLING_ACTIVE, NORMAL_LAMP}, 0);
		wait_trig(30);
		chk(FORCED, 1);
		for (int i = 1; i < 4; i++)
		begin
			pulse(SLOPE_PRESS);
			chk(SLOPE_ACTIVE, i % 3);
		end
		TYPE_SEL = 3'h1;
		pulse(TYPE_WRITE);
		TYPE_SEL = 3'h7;
		pulse(TYPE_WRITE);
		chk(TYPE_ACTIVE, 1);
		pulse(AUTOMATIC_SETUP);
		chk(TYPE_ACTIVE, 0);
		$display("test settings done");
		COUPLING_SEL = 3'h4;
		pulse(COUPLING_WRITE);
		chk(LOWPASS_COUPLING, 1);
		COUPLING_SEL = 3'h5;
		pulse(COUPLING_WRITE);
		chk({LOWPASS_COUPLING, NOISE_REDUCTION_COUPLING}, 1);
		COUPLING_SEL = 3'h3;
		pulse(COUPLING_WRITE);
		chk({HIGH_FREQ_REJECT_COUPLING, COUPLING_ACTIVE}, 4'hb);
		COUPLING_SEL = 3'h1;
		pulse(COUPLING_WRITE);
		chk(PEAK_LIMIT_EN, 1);
		pulse(RUN_MODE_TOGGLE);
		chk({NORMAL_LAMP, PEAK_LIMIT_EN}, 2);
		count(30, c);
		chk(c, 0);
		lvl[0] = 1'b1;
		wait_trig(4);
		chk(FORCED, 0);
		$display("test modes done");
		TYPE_SEL = 3'h1;
		pulse(TYPE_WRITE);
		foreach (tbl[k])
		begin
			NEGATIVE_POLARITY = 1'(tbl[k][0]);
			CMP_SEL = 3'(tbl[k][1]);
			lvl[0] = 1'(tbl[k][0]);
			tick(6);
			lvl[0] = !lvl[0];
			count(tbl[k][2], c1);
			lvl[0] = !lvl[0];
			count(4, c2);
			chk({c1[3:0], c2[3:0]}, tbl[k][3]);
		end
		// above 1 ms the reference snaps down to a 1 us grid
		REF_T1_NS = 36'hf4627;
		CMP_SEL = 3'h0;
		NEGATIVE_POLARITY = 1'b0;
		lvl[0] = 1'b1;
		count(10001, c1);
		lvl[0] = 1'b0;
		count(4, c2);
		chk({c1[3:0], c2[3:0]}, 1);
		REF_T1_NS = 36'h1f4;
		$display("test pulse done");
		pulse(AUTOMATIC_SETUP);
		lvl[0] = 1'b0;
		HOLDOFF_EN = 1'b1;
		tick(2);
		c = 0;
		repeat (8)
		begin
			lvl[0] = 1'b1;
			count(3, c1);
			lvl[0] = 1'b0;
			count(2, c2);
			c += c1 + c2;
		end
		chk(c, 3);
		HOLDOFF_EN = 1'b0;
		SOURCE_SEL = 2'h2;
		DIGITAL_SEL = 3'h5;
		for (int p = 1; p >= 0; p--)
		begin
			PROBE_PRESENT = 1'(p);
			dig = 8'h0;
			tick(2);
			dig = 8'h20;
			count(4, c);
			chk(c, p);
		end
		SOURCE_SEL = 2'h3;
		wait_trig(120);
		// second channel with both slopes: rise and fall each fire
		SOURCE_SEL = 2'h1;
		pulse(SLOPE_PRESS);
		pulse(SLOPE_PRESS);
		lvl[1] = 1'b1;
		count(3, c1);
		lvl[1] = 1'b0;
		count(3, c2);
		chk({c1[3:0], c2[3:0]}, 8'h11);
		pulse(SLOPE_PRESS);
		SOURCE_SEL = 2'h0;
		$display("test sources done");
		pulse(SINGLE_PRESS);
		chk(STOPPED, 0);
		lvl[0] = 1'b1;
		wait_trig(5);
		tick();
		chk({STOPPED, RUN_LAMP}, 3);
		lvl[0] = 1'b0;
		tick(2);
		lvl[0] = 1'b1;
		count(5, c);
		chk(c, 0);
		$display("test single done");
		conclude();
	end
endmodule

bind scope_trigger_unit trig_assertions chk_u (.REF_CLK, .RESETN,
	.SLOPE_PRESS, .AUTOMATIC_SETUP, .TRIGGER, .FORCED, .NORMAL_LAMP,
	.RUN_LAMP, .STOPPED, .ACQ_ACCEPT, .LOWPASS_COUPLING,
	.NOISE_REDUCTION_COUPLING, .TYPE_ACTIVE, .SLOPE_ACTIVE);

// *** bench/trig_assertions.sv ***
// port checker for the trigger decision unit
module trig_assertions
(
	// clock, reset and strobes
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic SLOPE_PRESS,
	input wire logic AUTOMATIC_SETUP,
	// results
	input wire logic TRIGGER,
	input wire logic FORCED,
	input wire logic NORMAL_LAMP,
	input wire logic RUN_LAMP,
	input wire logic STOPPED,
	input wire logic ACQ_ACCEPT,
	input wire logic LOWPASS_COUPLING,
	input wire logic NOISE_REDUCTION_COUPLING,
	input wire logic [2:0] TYPE_ACTIVE,
	input wire logic [1:0] SLOPE_ACTIVE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);
	// filters, trigger pulses, slope and type keys, run state
	a_filters_exclusive: assert property (
		!(LOWPASS_COUPLING && NOISE_REDUCTION_COUPLING))
		else $error("lowpass with noise reduction");
	a_acq_on_trig: assert property (ACQ_ACCEPT == TRIGGER)
		else $error("accept differs from trigger");
	a_forced_trig: assert property (FORCED |-> TRIGGER)
		else $error("forced without trigger");
	a_forced_auto: assert property (FORCED |-> !$past(NORMAL_LAMP))
		else $error("forced in normal mode");
	a_forced_gap: assert property (FORCED |=> !FORCED [*8])
		else $error("forced too soon");
	a_slope_step: assert property (SLOPE_PRESS |=> SLOPE_ACTIVE ==
		(($past(SLOPE_ACTIVE) == 2'h2) ? 2'h0 : $past(SLOPE_ACTIVE) + 2'h1))
		else $error("slope order wrong");
	a_setup_edge: assert property (
		AUTOMATIC_SETUP |=> TYPE_ACTIVE == 3'h0)
		else $error("setup left type");
	a_stop_lamp: assert property (STOPPED |-> RUN_LAMP)
		else $error("lamp not steady");
	a_stop_quiet: assert property (
		STOPPED && $past(STOPPED) |-> !TRIGGER)
		else $error("trigger while stopped");
	c_forced: cover property (FORCED);
	c_stop: cover property ($rose(STOPPED));
	c_norm_trig: cover property (TRIGGER && NORMAL_LAMP);
endmodule

// *** rtl/scope_trigger_unit.sv ***
// trigger decision unit: source select, edge and pulse-width trigger, modes
// What this block does
// - one trigger type active at a time
// - mode key toggles auto/normal, lamp lit normal
// - auto mode forces trigger without any match, except while single is armed or stopped
// - normal mode accepts only real matches
// - single arms, blinks, stops after first match
// - source: two channels, eight digital, mains
// - edge trigger on level crossing, chosen slope
// - slope key cycles rise, fall, both
// - automatic setup forces edge type
// - six couplings, auto level after reset
// - ac coupling limits level only in auto
// - lowpass and noise reduction never together
// - pulse trigger fires on trailing edge
// - polarity picks which edges bound width
// - six width comparisons supported
// - equal/unequal use reference plus deviation
// - window strict bounds, inverse outside
// - reference time spans 16 ns to 34.36 s
// - 2 ns resolution to 1 ms, coarser above
// - deviation 8 ns steps to 657.5 us
// - hold-off disarms 50 ns to 10 s
module scope_trigger_unit #(
	parameter int AUTO_TIMEOUT = trig_pkg::AUTO_TIMEOUT_CYC
)
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// front panel strobes, one cycle each
	input wire logic RUN_MODE_TOGGLE,
	input wire logic SINGLE_PRESS,
	input wire logic SLOPE_PRESS,
	input wire logic AUTOMATIC_SETUP,
	input wire logic TYPE_WRITE,
	input wire logic [2:0] TYPE_SEL,
	input wire logic COUPLING_WRITE,
	input wire logic [2:0] COUPLING_SEL,
	// configuration levels
	input wire logic [1:0] SOURCE_SEL,
	input wire logic [2:0] DIGITAL_SEL,
	input wire logic PROBE_PRESENT,
	input wire logic NEGATIVE_POLARITY,
	input wire logic [2:0] CMP_SEL,
	input wire logic [trig_pkg::REF_W-1:0] REF_T1_NS,
	input wire logic [trig_pkg::REF_W-1:0] REF_T2_NS,
	input wire logic [trig_pkg::DEV_W-1:0] DEV_STEPS,
	input wire logic HOLDOFF_EN,
	input wire logic [trig_pkg::HOLD_W-1:0] HOLDOFF_NS,
	// comparator outputs: signal above trigger level
	input wire logic CH1_ABOVE,
	input wire logic CH2_ABOVE,
	input wire logic [trig_pkg::DIG_N-1:0] DIGITAL_IN,
	input wire logic MAINS_LINE_SOURCE,
	// status and results
	output logic TRIGGER,
	output logic FORCED,
	output logic NORMAL_LAMP,
	output logic RUN_LAMP,
	output logic STOPPED,
	output logic ACQ_ACCEPT,
	output logic PEAK_LIMIT_EN,
	output logic LOWPASS_COUPLING,
	output logic NOISE_REDUCTION_COUPLING,
	output logic HIGH_FREQ_REJECT_COUPLING,
	output logic [2:0] TYPE_ACTIVE,
	output logic [1:0] SLOPE_ACTIVE,
	output logic [2:0] COUPLING_ACTIVE
);

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	typedef struct packed
	{
		trig_pkg::trig_type_e ttype;
		trig_pkg::slope_e slope;
		trig_pkg::coupling_e cpl;
		logic normal;
		trig_pkg::run_state_e run;
		logic src_prev;
		logic [trig_pkg::WIDTH_W-1:0] width;
		logic [trig_pkg::HOLD_W-1:0] hold;
		logic [31:0] auto_cnt;
		logic [23:0] blink;
		logic trig;
		logic forced;
		logic accept;
	} state_s;

	state_s cur_ff;
	state_s nxt_st;

	logic src;
	logic rise;
	logic fall;
	logic edge_hit;
	logic pulse_end;
	logic width_ok;
	logic real_hit;
	logic [trig_pkg::REF_W-1:0] t1_q;
	logic [trig_pkg::REF_W-1:0] t2_q;
	logic [trig_pkg::REF_W-1:0] dev_ns;
	logic [trig_pkg::REF_W-1:0] lo_eq;
	logic [trig_pkg::REF_W-1:0] hi_eq;
	logic in_tol;
	logic armed;

	// -------------------------------------------------------------------
	// source select and edges
	// -------------------------------------------------------------------
	// digital probes only count when the pod is plugged in
	always_comb
	begin
		unique case (trig_pkg::source_e'(SOURCE_SEL))
			trig_pkg::SRC_CH1: src = CH1_ABOVE;
			trig_pkg::SRC_CH2: src = CH2_ABOVE;
			trig_pkg::SRC_DIGITAL: src = PROBE_PRESENT &
				DIGITAL_IN[DIGITAL_SEL];
			trig_pkg::SRC_MAINS: src = MAINS_LINE_SOURCE;
		endcase
	end

	// level crossing seen as a change of the above-level comparator
	assign rise = src & ~cur_ff.src_prev;
	assign fall = ~src & cur_ff.src_prev;
	assign edge_hit = (cur_ff.slope == trig_pkg::SLOPE_RISE) ? rise :
		(cur_ff.slope == trig_pkg::SLOPE_FALL) ? fall : (rise | fall);

	// trailing edge ends the pulse: falling for positive, rising negative
	assign pulse_end = NEGATIVE_POLARITY ? rise : fall;

	// -------------------------------------------------------------------
	// reference quantisation and width comparison
	// -------------------------------------------------------------------
	// fine 2 ns grid below 1 ms, 1 us grid above; clamp to 16 ns floor
	function automatic logic [trig_pkg::REF_W-1:0] quant
	(
		input logic [trig_pkg::REF_W-1:0] t
	);
		logic [trig_pkg::REF_W-1:0] r;
		r = t;
		if (r < trig_pkg::REF_W'(trig_pkg::REF_MIN_NS))
			r = trig_pkg::REF_W'(trig_pkg::REF_MIN_NS);
		if (r <= trig_pkg::REF_W'(trig_pkg::REF_FINE_LIMIT_NS))
			r = r - (r % trig_pkg::REF_W'(trig_pkg::REF_RES_NS));
		else
			r = r - (r % trig_pkg::REF_W'(trig_pkg::REF_COARSE_NS));
		return r;
	endfunction

	assign t1_q = quant(REF_T1_NS);
	assign t2_q = quant(REF_T2_NS);
	// deviation counts 8 ns steps
	assign dev_ns = trig_pkg::REF_W'(DEV_STEPS) *
		trig_pkg::REF_W'(trig_pkg::DEV_RES_NS);
	assign lo_eq = (t1_q > dev_ns) ? (t1_q - dev_ns) : '0;
	assign hi_eq = t1_q + dev_ns;
	assign in_tol = (cur_ff.width >= lo_eq) && (cur_ff.width <= hi_eq);

	// width is held in ns, resolution one sample clock
	always_comb
	begin
		unique case (trig_pkg::cmp_e'(CMP_SEL))
			trig_pkg::CMP_GT: width_ok = cur_ff.width > t1_q;
			trig_pkg::CMP_LT: width_ok = cur_ff.width < t1_q;
			trig_pkg::CMP_EQ: width_ok = in_tol;
			trig_pkg::CMP_NE: width_ok = ~in_tol;
			trig_pkg::CMP_IN: width_ok = (cur_ff.width > t1_q) &&
				(cur_ff.width < t2_q);
			trig_pkg::CMP_OUT: width_ok = ~((cur_ff.width > t1_q) &&
				(cur_ff.width < t2_q));
			default: width_ok = 1'b0;
		endcase
	end

	// only edge and pulse types are decided here; others never match
	always_comb
	begin
		unique case (cur_ff.ttype)
			trig_pkg::TYPE_EDGE: real_hit = edge_hit;
			trig_pkg::TYPE_PULSE: real_hit = pulse_end & width_ok;
			default: real_hit = 1'b0;
		endcase
	end

	assign armed = (cur_ff.hold == '0) &&
		(cur_ff.run != trig_pkg::RUN_STOPPED);

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb
	begin
		nxt_st = cur_ff;
		nxt_st.src_prev = src;
		nxt_st.trig = 1'b0;
		nxt_st.forced = 1'b0;
		nxt_st.accept = 1'b0;
		nxt_st.blink = cur_ff.blink + 24'h000001;

		// type selection; automatic setup has priority
		if (AUTOMATIC_SETUP)
			nxt_st.ttype = trig_pkg::TYPE_EDGE;
		else if (TYPE_WRITE && TYPE_SEL <= 3'(trig_pkg::TYPE_HOLDOFF))
			nxt_st.ttype = trig_pkg::trig_type_e'(TYPE_SEL);

		if (SLOPE_PRESS)
		begin
			unique case (cur_ff.slope)
				trig_pkg::SLOPE_RISE: nxt_st.slope = trig_pkg::SLOPE_FALL;
				trig_pkg::SLOPE_FALL: nxt_st.slope = trig_pkg::SLOPE_BOTH;
				default: nxt_st.slope = trig_pkg::SLOPE_RISE;
			endcase
		end

		// one enum field makes lowpass and noise reduction exclusive
		if (COUPLING_WRITE && COUPLING_SEL <= 3'(trig_pkg::CPL_NOISE_RED))
			nxt_st.cpl = trig_pkg::coupling_e'(COUPLING_SEL);

		if (RUN_MODE_TOGGLE)
			nxt_st.normal = ~cur_ff.normal;

		// single press re-arms even from stopped
		if (SINGLE_PRESS)
			nxt_st.run = trig_pkg::RUN_SINGLE_ARMED;
		else if (RUN_MODE_TOGGLE)
			nxt_st.run = trig_pkg::RUN_FREE;

		// pulse width between the opening and trailing edge, saturating
		if (pulse_end || (NEGATIVE_POLARITY ? src : ~src))
			nxt_st.width = '0;
		else if (cur_ff.width <= trig_pkg::WIDTH_MAX - trig_pkg::CLK_NS)
			nxt_st.width = cur_ff.width + trig_pkg::CLK_NS;
		else
			nxt_st.width = trig_pkg::WIDTH_MAX;

		// hold-off counts down in ns, floor of one clock
		if (cur_ff.hold > trig_pkg::HOLD_W'(trig_pkg::CLK_PERIOD_NS))
			nxt_st.hold = cur_ff.hold -
				trig_pkg::HOLD_W'(trig_pkg::CLK_PERIOD_NS);
		else
			nxt_st.hold = '0;

		if (armed)
		begin
			if (real_hit)
			begin
				nxt_st.trig = 1'b1;
				nxt_st.accept = 1'b1;
				nxt_st.auto_cnt = '0;
			end
			else if (!cur_ff.normal &&
				cur_ff.run == trig_pkg::RUN_FREE &&
				cur_ff.auto_cnt >= 32'(AUTO_TIMEOUT - 1))
			begin
				nxt_st.trig = 1'b1;
				nxt_st.forced = 1'b1;
				nxt_st.accept = 1'b1;
				nxt_st.auto_cnt = '0;
			end
			else
				nxt_st.auto_cnt = cur_ff.auto_cnt + 32'h00000001;
			if (nxt_st.trig)
			begin
				if (cur_ff.run == trig_pkg::RUN_SINGLE_ARMED)
					nxt_st.run = trig_pkg::RUN_STOPPED;
				if (HOLDOFF_EN)
					nxt_st.hold = (HOLDOFF_NS <
						trig_pkg::HOLD_W'(trig_pkg::HOLDOFF_MIN_NS)) ?
						trig_pkg::HOLD_W'(trig_pkg::HOLDOFF_MIN_NS) :
						HOLDOFF_NS;
			end
		end
	end

	// -------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			cur_ff <= '{ttype: trig_pkg::TYPE_EDGE,
				slope: trig_pkg::SLOPE_RISE,
				cpl: trig_pkg::CPL_AUTO_LEVEL,
				run: trig_pkg::RUN_FREE,
				default: '0};
		end
		else
			cur_ff <= nxt_st;
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------
	assign TRIGGER = cur_ff.trig;
	assign FORCED = cur_ff.forced;
	assign ACQ_ACCEPT = cur_ff.accept;
	assign NORMAL_LAMP = cur_ff.normal;
	assign STOPPED = cur_ff.run == trig_pkg::RUN_STOPPED;
	// blinks while armed, steady once stopped
	assign RUN_LAMP = (cur_ff.run == trig_pkg::RUN_SINGLE_ARMED) ?
		cur_ff.blink[trig_pkg::BLINK_BIT] : STOPPED;
	// peak-to-peak limiting only with ac coupling in auto mode
	assign PEAK_LIMIT_EN = (cur_ff.cpl == trig_pkg::CPL_AC) &
		~cur_ff.normal;
	assign LOWPASS_COUPLING = cur_ff.cpl == trig_pkg::CPL_LOWPASS;
	assign NOISE_REDUCTION_COUPLING = cur_ff.cpl == trig_pkg::CPL_NOISE_RED;
	assign HIGH_FREQ_REJECT_COUPLING = cur_ff.cpl ==
		trig_pkg::CPL_HIFREQ_REJECT;
	assign TYPE_ACTIVE = cur_ff.ttype;
	assign SLOPE_ACTIVE = cur_ff.slope;
	assign COUPLING_ACTIVE = cur_ff.cpl;

endmodule

// *** rtl/trig_pkg.sv ***
// constants and types shared by the trigger decision unit
package trig_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int HOLDOFF_MIN_NS = 50;
	localparam int HOLDOFF_MIN_CYC = (HOLDOFF_MIN_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int AUTO_TIMEOUT_MS = 100;
	localparam int AUTO_TIMEOUT_CYC = AUTO_TIMEOUT_MS * 1000000 /
		CLK_PERIOD_NS;
	// reference time: 16 ns .. 34.36 s, 2 ns steps below 1 ms, 1 us above
	localparam int REF_RES_NS = 2;
	localparam int REF_COARSE_NS = 1000;
	localparam int REF_FINE_LIMIT_NS = 1000000;
	localparam int REF_MIN_NS = 16;
	localparam int REF_W = 36;
	// deviation: 8 ns steps up to 657.5 us
	localparam int DEV_RES_NS = 8;
	localparam int DEV_W = 17;
	// hold-off time held in ns: 10 s fits in 34 bits
	localparam int HOLD_W = 34;
	localparam int WIDTH_W = 36;
	localparam logic [WIDTH_W-1:0] WIDTH_MAX = '1;
	localparam logic [REF_W-1:0] CLK_NS = REF_W'(CLK_PERIOD_NS);
	localparam int DIG_N = 8;

	typedef enum logic [2:0]
	{
		TYPE_EDGE = 3'h0,
		TYPE_PULSE = 3'h1,
		TYPE_LOGIC = 3'h2,
		TYPE_VIDEO = 3'h3,
		TYPE_HOLDOFF = 3'h4
	} trig_type_e;

	typedef enum logic [1:0]
	{
		SLOPE_RISE = 2'h0,
		SLOPE_FALL = 2'h1,
		SLOPE_BOTH = 2'h2
	} slope_e;

	typedef enum logic [2:0]
	{
		CPL_AUTO_LEVEL = 3'h0,
		CPL_AC = 3'h1,
		CPL_DC = 3'h2,
		CPL_HIFREQ_REJECT = 3'h3,
		CPL_LOWPASS = 3'h4,
		CPL_NOISE_RED = 3'h5
	} coupling_e;

	typedef enum logic [2:0]
	{
		CMP_GT = 3'h0,
		CMP_LT = 3'h1,
		CMP_EQ = 3'h2,
		CMP_NE = 3'h3,
		CMP_IN = 3'h4,
		CMP_OUT = 3'h5
	} cmp_e;

	typedef enum logic [1:0]
	{
		SRC_CH1 = 2'h0,
		SRC_CH2 = 2'h1,
		SRC_DIGITAL = 2'h2,
		SRC_MAINS = 2'h3
	} source_e;

	typedef enum logic [1:0]
	{
		RUN_FREE = 2'h0,
		RUN_SINGLE_ARMED = 2'h1,
		RUN_STOPPED = 2'h2
	} run_state_e;

	// run lamp follows this counter bit: a period of 2^24 clocks
	localparam int BLINK_BIT = 23;
endpackage
